// [rtl/dc_timing_ctrl.sv]
// Display cache SDRAM timing controller: register file, command gating and special cycles.
`timescale 1ns/1ns
module dc_timing_ctrl
  import dc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Register access
  input  wire logic [31:0] MMIO_BASE,
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_IO,
  input  wire logic        MEM_WR,
  input  wire logic [31:0] MEM_ADDR,
  input  wire logic [7:0]  MEM_WDATA,
  output logic             MEM_ACK,
  output logic [7:0]       MEM_RDATA,
  // Command engine
  input  wire logic        CMD_VALID,
  input  wire mem_req_t    CMD_REQ,
  output logic             CMD_READY,
  // SDRAM command output and settings
  output sd_out_t          SD_OUT,
  output timing_t          TIMING,
  output logic             CACHE_FITTED,
  output logic             PAGE_CLOSE,
  output logic             REFRESH_EN,
  output logic [2:0]       SPECIAL_SEL
);

  // ----------------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n;

  // Release is synchronised so every flop leaves reset on the same edge.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  logic [7:0] presence_ff;
  logic [7:0] timing_ff;
  logic [7:0] special_ff;
  logic       hit;
  logic [31:0] offset;

  function automatic logic [3:0] pick(input logic sel, input logic [3:0] when0, input logic [3:0] when1);
    pick = sel ? when1 : when0;
  endfunction

  // I/O-space cycles never match, even when the address would.
  assign offset = MEM_ADDR - MMIO_BASE;
  assign hit    = MEM_REQ && !MEM_IO;

  // Masks keep reserved bits at zero whatever software writes.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      presence_ff <= RST_PRESENCE;
      timing_ff   <= RST_TIMING;
      special_ff  <= RST_SPECIAL;
    end else if (hit && MEM_WR) begin
      if (offset == OFS_PRESENCE) presence_ff <= MEM_WDATA & MASK_PRESENCE;
      if (offset == OFS_TIMING)   timing_ff   <= MEM_WDATA & MASK_TIMING;
      if (offset == OFS_SPECIAL)  special_ff  <= MEM_WDATA & MASK_SPECIAL;
    end
  end

  // Every access is acknowledged next cycle; unmapped ones read zero.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      MEM_ACK   <= 1'b0;
      MEM_RDATA <= RDATA_NONE;
    end else begin
      MEM_ACK   <= MEM_REQ;
      MEM_RDATA <= RDATA_NONE;
      if (hit && !MEM_WR) begin
        if (offset == OFS_PRESENCE) MEM_RDATA <= presence_ff;
        if (offset == OFS_TIMING)   MEM_RDATA <= timing_ff;
        if (offset == OFS_SPECIAL)  MEM_RDATA <= special_ff;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------------------
  assign CACHE_FITTED = presence_ff[BIT_FITTED];
  assign PAGE_CLOSE   = timing_ff[BIT_PAGE];
  assign REFRESH_EN   = (special_ff[REF_MSB:REF_LSB] == REF_ON);
  assign SPECIAL_SEL  = special_ff[SMS_MSB:SMS_LSB];
  assign TIMING.cas   = pick(timing_ff[BIT_CAS], CAS_SHORT_CLKS, CAS_LONG_CLKS);
  assign TIMING.rcd   = timing_ff[BIT_OVERRIDE] ? RCD_FIXED_CLKS : TIMING.cas;
  assign TIMING.ras   = pick(timing_ff[BIT_ROWACT], RAS_SHORT_CLKS, RAS_LONG_CLKS);
  assign TIMING.rc    = pick(timing_ff[BIT_ROWACT], RC_SHORT_CLKS, RC_LONG_CLKS);
  assign TIMING.rp    = pick(timing_ff[BIT_PRECH], RP_SHORT_CLKS, RP_LONG_CLKS);

  // ----------------------------------------------------------------------------
  // Command conversion and timing gates
  // ----------------------------------------------------------------------------
  sd_cmd_t    nxt_cmd;
  logic [11:0] nxt_addr;
  logic       fire;
  logic       rcd_done;
  logic       ras_done;
  logic       rc_done;
  logic       rp_done;

  // Special modes override the requested operation for every cycle.
  always_comb begin
    nxt_addr = CMD_REQ.addr;
    case (SPECIAL_SEL)
      SMS_NORMAL: begin
        case (CMD_REQ.op)
          OP_ACT:   nxt_cmd = SD_ACT;
          OP_READ:  nxt_cmd = SD_READ;
          OP_WRITE: nxt_cmd = SD_WRITE;
          OP_PRE:   nxt_cmd = SD_PRE;
          OP_REF:   nxt_cmd = REFRESH_EN ? SD_REF : SD_NOP;
          default:  nxt_cmd = SD_NOP;
        endcase
      end
      SMS_NOP:  nxt_cmd = SD_NOP;
      SMS_PALL: nxt_cmd = SD_PALL;
      SMS_MRS: begin
        nxt_cmd  = SD_MRS;
        nxt_addr = {{(MRS_ZERO_MSB - MRS_ZERO_LSB + 1){1'b0}}, CMD_REQ.addr[MRS_ZERO_LSB-1:0]};
      end
      SMS_CBR:  nxt_cmd = SD_REF;
      default:  nxt_cmd = SD_NOP;  // Reserved codes issue nothing harmful.
    endcase
  end

  // A command waits until every interval that guards it has run out.
  always_comb begin
    case (nxt_cmd)
      SD_ACT:           CMD_READY = rp_done && rc_done;
      SD_READ,
      SD_WRITE:         CMD_READY = rcd_done;
      SD_PRE,
      SD_PALL:          CMD_READY = ras_done;
      SD_MRS:           CMD_READY = rp_done;
      SD_REF:           CMD_READY = rp_done && rc_done;
      default:          CMD_READY = 1'b1;
    endcase
  end

  assign fire = CMD_VALID && CMD_READY;

  // Command and address leave from flops one cycle after acceptance.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SD_OUT <= '{cmd: SD_NOP, addr: 12'h000};
    end else if (fire) begin
      SD_OUT <= '{cmd: nxt_cmd, addr: nxt_addr};
    end else begin
      SD_OUT <= '{cmd: SD_NOP, addr: 12'h000};
    end
  end

  // Timers load the figure current at issue, so changes affect later commands only.
  dc_min_timer u_rcd (.clk(CLK), .rst_n(rst_n), .load(fire && nxt_cmd == SD_ACT), .clks(TIMING.rcd),
                      .done(rcd_done));
  dc_min_timer u_ras (.clk(CLK), .rst_n(rst_n), .load(fire && nxt_cmd == SD_ACT), .clks(TIMING.ras),
                      .done(ras_done));
  dc_min_timer u_rc  (.clk(CLK), .rst_n(rst_n), .load(fire && nxt_cmd == SD_REF), .clks(TIMING.rc),
                      .done(rc_done));
  dc_min_timer u_rp  (.clk(CLK), .rst_n(rst_n), .load(fire && (nxt_cmd == SD_PRE || nxt_cmd == SD_PALL)),
                      .clks(TIMING.rp), .done(rp_done));

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  logic [3:0] gap_act_ff;
  logic [3:0] gap_ref_ff;
  logic [3:0] gap_pre_ff;

  // Saturating distances since the last activate, refresh and precharge (PRE or PALL) on the output.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      gap_act_ff <= GAP_MAX;
      gap_ref_ff <= GAP_MAX;
      gap_pre_ff <= GAP_MAX;
    end else begin
      gap_act_ff <= (SD_OUT.cmd == SD_ACT) ? GAP_ONE : ((gap_act_ff == GAP_MAX) ? GAP_MAX : gap_act_ff + GAP_ONE);
      gap_ref_ff <= (SD_OUT.cmd == SD_REF) ? GAP_ONE : ((gap_ref_ff == GAP_MAX) ? GAP_MAX : gap_ref_ff + GAP_ONE);
      gap_pre_ff <= (SD_OUT.cmd == SD_PRE || SD_OUT.cmd == SD_PALL) ? GAP_ONE :
                    ((gap_pre_ff == GAP_MAX) ? GAP_MAX : gap_pre_ff + GAP_ONE);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_mrs_taken;
    fire && SPECIAL_SEL == SMS_MRS;
  endsequence

  a_rcd_gap: assert property ((SD_OUT.cmd == SD_READ || SD_OUT.cmd == SD_WRITE) |-> gap_act_ff >= TIMING.rcd)
    else $error("Read or write too soon after activate.");
  a_ras_gap: assert property ((SD_OUT.cmd == SD_PRE || SD_OUT.cmd == SD_PALL) |-> gap_act_ff >= TIMING.ras)
    else $error("Precharge too soon after activate.");
  a_rc_gap: assert property (SD_OUT.cmd == SD_ACT |-> gap_ref_ff >= TIMING.rc && gap_pre_ff >= TIMING.rp)
    else $error("Activate too soon after refresh or precharge.");
  a_mrs_addr: assert property (s_mrs_taken |=> SD_OUT.cmd == SD_MRS && SD_OUT.addr[11:7] == 5'h00
    && SD_OUT.addr[6:0] == $past(CMD_REQ.addr[6:0]))
    else $error("Mode-set address wrong.");
  a_refresh_gate: assert property (fire && SPECIAL_SEL == SMS_NORMAL && CMD_REQ.op == OP_REF && !REFRESH_EN
    |=> SD_OUT.cmd == SD_NOP)
    else $error("Refresh issued while disabled.");
  a_special_conv: assert property (fire && SPECIAL_SEL == SMS_PALL |=> SD_OUT.cmd == SD_PALL)
    else $error("Precharge-all mode not applied.");
  a_io_ignored: assert property (MEM_REQ && MEM_IO |=> $stable(presence_ff) && $stable(timing_ff)
    && $stable(special_ff) && MEM_RDATA == RDATA_NONE)
    else $error("I/O-space access reached the registers.");
  a_reserved_zero: assert property (presence_ff[7:1] == 7'h00 && timing_ff[7:5] == 3'h0
    && special_ff[7:5] == 3'h0)
    else $error("Reserved register bit is set.");
  a_cas_decode: assert property (TIMING.cas == (timing_ff[BIT_CAS] ? 4'h3 : 4'h2)
    && TIMING.rp == (timing_ff[BIT_PRECH] ? 4'h3 : 4'h2))
    else $error("Latency or precharge decode wrong.");

endmodule

// [rtl/dc_pkg.sv]
// Shared constants and types for the display cache SDRAM timing controller.
package dc_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets from the memory-mapped base, reset values, writable masks
  // ----------------------------------------------------------------------------
  localparam logic [31:0] OFS_PRESENCE = 32'h0000_3000;
  localparam logic [31:0] OFS_TIMING   = 32'h0000_3001;
  localparam logic [31:0] OFS_SPECIAL  = 32'h0000_3002;
  localparam logic [7:0]  RST_PRESENCE = 8'h00;
  localparam logic [7:0]  RST_TIMING   = 8'h17;
  localparam logic [7:0]  RST_SPECIAL  = 8'h08;
  localparam logic [7:0]  MASK_PRESENCE = 8'h01;
  localparam logic [7:0]  MASK_TIMING   = 8'h1F;
  localparam logic [7:0]  MASK_SPECIAL  = 8'h1F;
  localparam logic [7:0]  RDATA_NONE    = 8'h00;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int unsigned BIT_FITTED   = 0;
  localparam int unsigned BIT_PAGE     = 4;
  localparam int unsigned BIT_OVERRIDE = 3;
  localparam int unsigned BIT_CAS      = 2;
  localparam int unsigned BIT_ROWACT   = 1;
  localparam int unsigned BIT_PRECH    = 0;
  localparam int unsigned REF_MSB      = 4;
  localparam int unsigned REF_LSB      = 3;
  localparam int unsigned SMS_MSB      = 2;
  localparam int unsigned SMS_LSB      = 0;
  localparam int unsigned MRS_ZERO_MSB = 11;
  localparam int unsigned MRS_ZERO_LSB = 7;

  // ----------------------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------------------
  localparam logic [1:0] REF_OFF    = 2'h0;
  localparam logic [1:0] REF_ON     = 2'h1;
  localparam logic [2:0] SMS_NORMAL = 3'h0;
  localparam logic [2:0] SMS_NOP    = 3'h1;
  localparam logic [2:0] SMS_PALL   = 3'h2;
  localparam logic [2:0] SMS_MRS    = 3'h3;
  localparam logic [2:0] SMS_CBR    = 3'h4;

  // ----------------------------------------------------------------------------
  // Timing figures in local memory clocks
  // ----------------------------------------------------------------------------
  localparam logic [3:0] RCD_FIXED_CLKS = 4'h2;
  localparam logic [3:0] CAS_SHORT_CLKS = 4'h2;
  localparam logic [3:0] CAS_LONG_CLKS  = 4'h3;
  localparam logic [3:0] RAS_SHORT_CLKS = 4'h5;
  localparam logic [3:0] RAS_LONG_CLKS  = 4'h7;
  localparam logic [3:0] RC_SHORT_CLKS  = 4'h8;
  localparam logic [3:0] RC_LONG_CLKS   = 4'hA;
  localparam logic [3:0] RP_SHORT_CLKS  = 4'h2;
  localparam logic [3:0] RP_LONG_CLKS   = 4'h3;
  localparam logic [3:0] GAP_MAX        = 4'hF;
  localparam logic [3:0] GAP_ONE        = 4'h1;
  localparam logic [3:0] CNT_ZERO       = 4'h0;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_REF} op_t;
  typedef enum logic [2:0] {SD_NOP, SD_ACT, SD_READ, SD_WRITE, SD_PRE, SD_PALL, SD_MRS, SD_REF} sd_cmd_t;

  typedef struct packed {
    op_t        op;
    logic [11:0] addr;
  } mem_req_t;

  typedef struct packed {
    sd_cmd_t    cmd;
    logic [11:0] addr;
  } sd_out_t;

  typedef struct packed {
    logic [3:0] cas;
    logic [3:0] rcd;
    logic [3:0] ras;
    logic [3:0] rc;
    logic [3:0] rp;
  } timing_t;

endpackage

// [rtl/dc_min_timer.sv]
// Down counter that holds off a command for a minimum number of clocks.
`timescale 1ns/1ns
module dc_min_timer
  import dc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Start and figure
  input  wire logic       load,
  input  wire logic [3:0] clks,
  // State
  output logic            done
);

  logic [3:0] count_ff;

  // Loading N-1 lets the next command leave exactly N clocks after this one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= CNT_ZERO;
    end else if (load) begin
      count_ff <= clks - GAP_ONE;
    end else if (count_ff != CNT_ZERO) begin
      count_ff <= count_ff - GAP_ONE;
    end
  end

  assign done = (count_ff == CNT_ZERO);

endmodule

// [bench/dc_sdram_model.sv]
// Behavioural display cache SDRAM that counts command spacing faults.
`timescale 1ns/1ns
module dc_sdram_model
  import dc_pkg::*;
(
  // Clock and command bus
  input  wire logic    clk,
  input  wire sd_out_t sd,
  // Gaps the part needs
  input  wire timing_t need,
  // Fault count
  output int           viol
);
  int cyc;
  int t_act;
  int t_pre;
  int t_ref;

  // A real part corrupts data silently on a short gap, so every short gap is counted.
  initial begin
    viol = 0;
    cyc = 0;
    t_act = -99;
    t_pre = -99;
    t_ref = -99;
  end

  // Commands are sampled mid-cycle, well clear of the edge that launches them.
  always @(negedge clk) begin
    cyc++;
    case (sd.cmd)
      SD_ACT: begin
        if (cyc - t_pre < need.rp || cyc - t_ref < need.rc) viol++;
        t_act = cyc;
      end
      SD_READ, SD_WRITE: if (cyc - t_act < need.rcd) viol++;
      SD_PRE, SD_PALL: begin
        if (cyc - t_act < need.ras) viol++;
        t_pre = cyc;
      end
      SD_MRS: if (cyc - t_pre < need.rp || sd.addr[11:7] !== 5'h00) viol++;
      SD_REF: begin
        if (cyc - t_pre < need.rp || cyc - t_ref < need.rc) viol++;
        t_ref = cyc;
      end
      default: ;
    endcase
  end
endmodule

// [bench/tb.sv]
// Self-checking testbench for the display cache SDRAM timing controller.
`timescale 1ns/1ns
module tb
  import dc_pkg::*;
;
  localparam logic [31:0] BASE = 32'h1000_0000;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        MEM_REQ = 1'b0;
  logic        MEM_IO = 1'b0;
  logic        MEM_WR = 1'b0;
  logic [31:0] MEM_ADDR = 32'h0;
  logic [7:0]  MEM_WDATA = 8'h00;
  logic        CMD_VALID = 1'b0;
  mem_req_t    CMD_REQ = '{OP_ACT, 12'h000};
  logic        MEM_ACK, CMD_READY, CACHE_FITTED, PAGE_CLOSE, REFRESH_EN;
  logic [7:0]  MEM_RDATA;
  logic [2:0]  SPECIAL_SEL;
  sd_out_t     SD_OUT;
  timing_t     TIMING;
  timing_t     need;
  int          viol, cyc, n_fail, comparisons;

  always #25 CLK = ~CLK;
  always @(negedge CLK) cyc++;

  dc_timing_ctrl dut (.CLK(CLK), .RST_N(RST_N), .MMIO_BASE(BASE), .MEM_REQ(MEM_REQ), .MEM_IO(MEM_IO),
    .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
    .CMD_VALID(CMD_VALID), .CMD_REQ(CMD_REQ), .CMD_READY(CMD_READY), .SD_OUT(SD_OUT), .TIMING(TIMING),
    .CACHE_FITTED(CACHE_FITTED), .PAGE_CLOSE(PAGE_CLOSE), .REFRESH_EN(REFRESH_EN), .SPECIAL_SEL(SPECIAL_SEL));
  dc_sdram_model sdram (.clk(CLK), .sd(SD_OUT), .need(need), .viol(viol));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [19:0] ex, input logic [19:0] got);
    comparisons++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Expected clock counts worked out from the timing register bits.
  function automatic timing_t exp_t(input logic [7:0] v);
    timing_t t;
    t.cas = v[2] ? 4'h3 : 4'h2;
    t.rcd = v[3] ? 4'h2 : t.cas;
    t.ras = v[1] ? 4'h7 : 4'h5;
    t.rc  = v[1] ? 4'hA : 4'h8;
    t.rp  = v[0] ? 4'h3 : 4'h2;
    return t;
  endfunction

  // One register cycle; the answer is looked at in the single cycle it stands.
  task automatic acc(input logic io, input logic wr, input logic [31:0] ofs, input logic [7:0] wd,
                     input logic [7:0] ex);
    @(posedge CLK);
    MEM_REQ <= 1'b1;
    MEM_IO <= io;
    MEM_WR <= wr;
    MEM_ADDR <= BASE + ofs;
    MEM_WDATA <= wd;
    @(posedge CLK);
    MEM_REQ <= 1'b0;
    #1;
    chk("ack", 20'h1, {19'h0, MEM_ACK});
    chk("rdata", {12'h0, ex}, {12'h0, MEM_RDATA});
  endtask

  task automatic wr(input logic [31:0] ofs, input logic [7:0] d);
    acc(1'b0, 1'b1, ofs, d, 8'h00);
  endtask

  task automatic rd(input logic [31:0] ofs, input logic [7:0] ex);
    acc(1'b0, 1'b0, ofs, 8'h00, ex);
  endtask

  // Holds a command until taken, then returns what the bus showed and when.
  task automatic issue(input op_t op, input logic [11:0] a, output sd_out_t so, output int at);
    int k;
    k = 0;
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD_REQ <= '{op, a};
    @(negedge CLK);
    while (CMD_READY !== 1'b1 && k < 40) begin
      @(negedge CLK);
      k++;
    end
    chk("ready", 20'h1, {19'h0, CMD_READY});
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    #1;
    so = SD_OUT;
    at = cyc;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_PRESENCE, 8'h00);
    rd(OFS_TIMING, 8'h17);
    rd(OFS_SPECIAL, 8'h08);
    chk("timing", exp_t(8'h17), TIMING);
    chk("refresh", 20'h1, {19'h0, REFRESH_EN});
  endtask

  // Reserved bits, an unmapped offset, an I/O cycle and a base-less address.
  task automatic t_regs;
    wr(OFS_PRESENCE, 8'hFF);
    wr(OFS_TIMING, 8'hFF);
    wr(OFS_SPECIAL, 8'hFF);
    rd(OFS_PRESENCE, 8'h01);
    rd(OFS_TIMING, 8'h1F);
    rd(OFS_SPECIAL, 8'h1F);
    chk("refresh", 20'h0, {19'h0, REFRESH_EN});
    chk("fitted", 20'h1, {19'h0, CACHE_FITTED});
    chk("page", 20'h1, {19'h0, PAGE_CLOSE});
    rd(OFS_SPECIAL + 32'h1, 8'h00);
    acc(1'b1, 1'b1, OFS_TIMING, 8'h00, 8'h00);
    acc(1'b1, 1'b0, OFS_TIMING, 8'h00, 8'h00);
    wr(OFS_TIMING - BASE, 8'h00);
    rd(OFS_TIMING, 8'h1F);
    wr(OFS_TIMING, 8'h00);
    wr(OFS_PRESENCE, 8'h00);
    chk("page", 20'h0, {19'h0, PAGE_CLOSE});
    chk("fitted", 20'h0, {19'h0, CACHE_FITTED});
    wr(OFS_SPECIAL, 8'h08);
  endtask

  task automatic t_decode;
    for (int i = 0; i < 32; i++) begin
      wr(OFS_TIMING, 8'(i));
      chk("timing", exp_t(8'(i)), TIMING);
    end
  endtask

  // Back-to-back commands must land exactly at each minimum gap.
  task automatic t_gaps(input logic [7:0] v, input op_t op, input sd_cmd_t ex);
    sd_out_t s;
    int t0, t1, t2, t3, t4;
    wr(OFS_TIMING, v);
    need = exp_t(v);
    repeat (12) @(posedge CLK);
    issue(OP_ACT, 12'h123, s, t0);
    chk("act", {17'h0, SD_ACT}, {17'h0, s.cmd});
    chk("act addr", 20'h00123, {8'h0, s.addr});
    issue(op, 12'h045, s, t1);
    chk("access", {17'h0, ex}, {17'h0, s.cmd});
    issue(OP_PRE, 12'h000, s, t2);
    issue(OP_REF, 12'h000, s, t3);
    issue(OP_ACT, 12'h123, s, t4);
    chk("rcd gap", 20'(need.rcd), 20'(t1 - t0));
    chk("ras gap", 20'(need.ras), 20'(t2 - t0));
    chk("rp gap", 20'(need.rp), 20'(t3 - t2));
    chk("rc gap", 20'(need.rc), 20'(t4 - t3));
    issue(OP_PRE, 12'h000, s, t0);
  endtask

  // Special codes 1 to 5 in turn, NOP first, then refresh switched off.
  task automatic t_special;
    logic [2:0] sc[4] = '{3'h2, 3'h3, 3'h4, 3'h5};
    sd_cmd_t ec[4] = '{SD_PALL, SD_MRS, SD_REF, SD_NOP};
    sd_out_t s;
    int t;
    wr(OFS_SPECIAL, 8'h09);
    issue(OP_ACT, 12'hFFF, s, t);
    chk("nop", {17'h0, SD_NOP}, {17'h0, s.cmd});
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SPECIAL, {5'h01, sc[i]});
      chk("sel", {17'h0, sc[i]}, {17'h0, SPECIAL_SEL});
      issue(OP_ACT, 12'hFFF, s, t);
      chk("special", {17'h0, ec[i]}, {17'h0, s.cmd});
      if (sc[i] == 3'h3) chk("mrs addr", 20'h0007F, {8'h0, s.addr});
    end
    wr(OFS_SPECIAL, 8'h00);
    chk("refresh", 20'h0, {19'h0, REFRESH_EN});
    issue(OP_REF, 12'h000, s, t);
    chk("no ref", {17'h0, SD_NOP}, {17'h0, s.cmd});
    wr(OFS_SPECIAL, 8'h08);
    chk("sdram faults", 20'h0, 20'(viol));
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // The whole run needs under two thousand cycles, so this only catches a hang.
  initial begin
    repeat (6000) @(posedge CLK);
    n_fail++;
    test_done;
  end

  // Main sequence.
  initial begin
    need = exp_t(8'h17);
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_reset;
    t_regs;
    t_decode;
    t_gaps(8'h17, OP_READ, SD_READ);
    t_gaps(8'h00, OP_WRITE, SD_WRITE);
    t_gaps(8'h0C, OP_READ, SD_READ);
    t_special;
    test_done;
  end
endmodule
